// ### rtl/epc_pkg.sv
// Constants and types shared by the programming control block and its array
package epc_pkg;

  // Printed offsets are word indices; byte address is four times the index
  localparam logic [29:0] CTRL_IDX = 30'h0000000D;
  localparam logic [29:0] STAT_IDX = 30'h0000000E;
  localparam logic [29:0] MEM_FIRST_IDX = 30'h00001000;
  localparam logic [29:0] MEM_LAST_IDX = 30'h00001EFF;
  localparam int MEM_BYTES = 3840;
  localparam int MEM_IDX_W = 12;

  localparam int CTRL_POWER_BIT = 0;
  localparam int CTRL_LATCH_BIT = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  localparam int STAT_BOOT_BIT = 0;
  localparam int STAT_VPP_BIT = 1;
  localparam int STAT_LATCHED_BIT = 2;
  localparam int STAT_RC_BIT = 3;
  localparam int STAT_DONE_BIT = 4;

  localparam logic [7:0] ERASED_BYTE = 8'h00;

  localparam int CLK_PERIOD_NS = 25;
  localparam int PROG_TIME_NS = 1000000;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WRITE,
    PH_READ_WAIT,
    PH_READ_DONE
  } epc_phase_t;

  typedef enum logic [1:0] {
    TGT_NONE,
    TGT_CTRL,
    TGT_STAT,
    TGT_MEM
  } epc_target_t;

endpackage

// ### rtl/epc_mem_if.sv
// Read and program port between the control logic and the byte array
`timescale 1ns/1ps
interface epc_mem_if;
  logic [11:0] rd_idx;
  logic [7:0] rd_data;
  logic wr_en;
  logic [11:0] wr_idx;
  logic [7:0] wr_data;

  modport ctrl (output rd_idx, input rd_data, output wr_en, output wr_idx, output wr_data);
  modport array (input rd_idx, output rd_data, input wr_en, input wr_idx, input wr_data);
endinterface

// ### rtl/epc_array.sv
// One-time-programmable byte array held in flip-flops
`timescale 1ns/1ps
module epc_array
  import epc_pkg::*;
#(
  parameter int DEPTH = MEM_BYTES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  epc_mem_if.array mem
);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] cells;
  } epc_array_state_t;

  epc_array_state_t st_reg;
  epc_array_state_t st_next;

  // Programming only moves bits away from the erased level
  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < DEPTH; i++) begin
      if (mem.wr_en && (int'(mem.wr_idx) == i)) begin
        st_next.cells[i] = st_reg.cells[i] | mem.wr_data;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg <= {DEPTH{ERASED_BYTE}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign mem.rd_data = (int'(mem.rd_idx) < DEPTH) ? st_reg.cells[mem.rd_idx] : ERASED_BYTE;

endmodule

// ### rtl/epc_top.sv
// Programming control, mode latch and AHB-Lite slave for the on-chip OTP memory
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
module epc_top
  import epc_pkg::*;
#(
  parameter int PROG_CYCLES_P = PROG_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic boot_entry_voltage_i,
  input wire logic boot_select_pin_i,
  input wire logic osc_is_rc_i,
  output logic boot_mode_o,
  output logic mode_valid_o,
  output logic start_in_boot_o,
  output logic vectors_from_otp_o,
  output logic program_power_o,
  output logic otp_programming_o
);

  localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_CYCLES_P - 1);

  typedef struct packed {
    epc_phase_t phase;
    epc_target_t target;
    logic [MEM_IDX_W-1:0] mem_off;
    logic latch_en;
    logic power_en;
    logic lat_valid;
    logic [MEM_IDX_W-1:0] lat_idx;
    logic [7:0] lat_data;
    logic [CNT_W-1:0] prog_cnt;
    logic prog_done;
    logic commit;
    logic mode_done;
    logic boot_mode;
    logic [31:0] hrdata;
  } epc_state_t;

  epc_state_t st_reg;
  epc_state_t st_next;

  epc_mem_if mem_bus ();

  epc_array #(
    .DEPTH(MEM_BYTES)
  ) u_array (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .mem(mem_bus.array)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address phase decode

  logic [29:0] req_idx;
  logic req_take;
  epc_target_t req_target;
  logic [MEM_IDX_W-1:0] req_off;
  logic [29:0] off_wide;

  assign req_idx = haddr_i[31:2];
  assign req_take = hsel_i && hready_i && ((htrans_i == HTRANS_NONSEQ) || (htrans_i == HTRANS_SEQ));
  assign off_wide = req_idx - MEM_FIRST_IDX;
  assign req_off = off_wide[MEM_IDX_W-1:0];

  // Misaligned or unmapped accesses fall to no target: read zero, write lost
  always_comb begin
    req_target = TGT_NONE;
    if (haddr_i[1:0] == 2'h0) begin
      if (req_idx == CTRL_IDX) begin
        req_target = TGT_CTRL;
      end else if (req_idx == STAT_IDX) begin
        req_target = TGT_STAT;
      end else if ((req_idx >= MEM_FIRST_IDX) && (req_idx <= MEM_LAST_IDX)) begin
        req_target = TGT_MEM;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read value of the addressed register or byte

  logic [7:0] ctrl_view;
  logic [7:0] stat_view;
  logic [7:0] mem_view;
  logic [31:0] read_word;

  always_comb begin
    ctrl_view = CTRL_RESET;
    ctrl_view[CTRL_LATCH_BIT] = st_reg.latch_en;
    ctrl_view[CTRL_POWER_BIT] = st_reg.power_en && st_reg.latch_en;
  end

  always_comb begin
    stat_view = 8'h00;
    stat_view[STAT_BOOT_BIT] = st_reg.boot_mode;
    stat_view[STAT_VPP_BIT] = boot_entry_voltage_i;
    stat_view[STAT_LATCHED_BIT] = st_reg.lat_valid;
    stat_view[STAT_RC_BIT] = osc_is_rc_i;
    stat_view[STAT_DONE_BIT] = st_reg.prog_done;
  end

  // Array cannot be read while it is set up for programming
  assign mem_view = st_reg.latch_en ? 8'h00 : mem_bus.rd_data;

  always_comb begin
    read_word = 32'h00000000;
    unique case (st_reg.target)
      TGT_CTRL: read_word = {24'h000000, ctrl_view};
      TGT_STAT: read_word = {24'h000000, stat_view};
      TGT_MEM: read_word = {24'h000000, mem_view};
      TGT_NONE: read_word = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic prog_active;

  // Timer runs only while the array is powered, a byte is latched and Vpp is up
  assign prog_active = st_reg.latch_en && st_reg.power_en && st_reg.lat_valid
    && boot_entry_voltage_i && !st_reg.prog_done;

  always_comb begin
    st_next = st_reg;
    st_next.commit = 1'b0;

    // Mode is caught once, in the first cycle after reset release
    if (!st_reg.mode_done) begin
      st_next.mode_done = 1'b1;
      st_next.boot_mode = boot_entry_voltage_i && boot_select_pin_i && !osc_is_rc_i;
    end

    // Data phase of the previous request
    unique case (st_reg.phase)
      PH_IDLE: begin
      end
      PH_WRITE: begin
        if (st_reg.target == TGT_CTRL) begin
          st_next.latch_en = hwdata_i[CTRL_LATCH_BIT];
          // Power can only be held together with latch enable
          st_next.power_en = hwdata_i[CTRL_POWER_BIT] && hwdata_i[CTRL_LATCH_BIT];
          if (!hwdata_i[CTRL_LATCH_BIT]) begin
            st_next.lat_valid = 1'b0;
          end
          if (!hwdata_i[CTRL_POWER_BIT] || !hwdata_i[CTRL_LATCH_BIT]) begin
            st_next.prog_cnt = '0;
            st_next.prog_done = 1'b0;
          end
        end else if ((st_reg.target == TGT_MEM) && st_reg.latch_en && !st_reg.power_en) begin
          st_next.lat_valid = 1'b1;
          st_next.lat_idx = st_reg.mem_off;
          st_next.lat_data = hwdata_i[7:0];
        end
      end
      PH_READ_WAIT: begin
        st_next.hrdata = read_word;
      end
      PH_READ_DONE: begin
      end
    endcase

    // Programming pulse; a dropout of Vpp restarts the full time
    if (prog_active) begin
      if (st_reg.prog_cnt == PROG_LAST) begin
        st_next.commit = 1'b1;
        st_next.prog_done = 1'b1;
      end else begin
        st_next.prog_cnt = st_reg.prog_cnt + CNT_W'(1);
      end
    end else if (!st_reg.prog_done) begin
      st_next.prog_cnt = '0;
    end

    // Address phase of a new request
    if (st_reg.phase == PH_READ_WAIT) begin
      st_next.phase = PH_READ_DONE;
    end else if (req_take) begin
      st_next.target = req_target;
      st_next.mem_off = req_off;
      st_next.phase = hwrite_i ? PH_WRITE : PH_READ_WAIT;
    end else begin
      st_next.phase = PH_IDLE;
      st_next.target = TGT_NONE;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg.phase <= PH_IDLE;
      st_reg.target <= TGT_NONE;
      st_reg.mem_off <= '0;
      st_reg.latch_en <= CTRL_RESET[CTRL_LATCH_BIT];
      st_reg.power_en <= CTRL_RESET[CTRL_POWER_BIT];
      st_reg.lat_valid <= 1'b0;
      st_reg.lat_idx <= '0;
      st_reg.lat_data <= 8'h00;
      st_reg.prog_cnt <= '0;
      st_reg.prog_done <= 1'b0;
      st_reg.commit <= 1'b0;
      st_reg.mode_done <= 1'b0;
      st_reg.boot_mode <= 1'b0;
      st_reg.hrdata <= 32'h00000000;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array port and outputs

  assign mem_bus.rd_idx = st_reg.mem_off;
  assign mem_bus.wr_en = st_reg.commit;
  assign mem_bus.wr_idx = st_reg.lat_idx;
  assign mem_bus.wr_data = st_reg.lat_data;

  // Read data phase holds one wait state so that hrdata comes from a flop
  assign hreadyout_o = (st_reg.phase != PH_READ_WAIT);
  assign hresp_o = HRESP_OKAY;
  assign hrdata_o = st_reg.hrdata;

  assign boot_mode_o = st_reg.boot_mode;
  assign mode_valid_o = st_reg.mode_done;
  assign start_in_boot_o = st_reg.mode_done && st_reg.boot_mode;
  assign vectors_from_otp_o = st_reg.mode_done && !st_reg.boot_mode;
  assign program_power_o = st_reg.power_en && st_reg.latch_en;
  assign otp_programming_o = st_reg.latch_en;

endmodule

// ### testbench/epc_checker.sv
// Port assertions for the OTP programming control block
`timescale 1ns/1ps
module epc_checker (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [31:0] hrdata_o,
  input wire logic boot_entry_voltage_i,
  input wire logic boot_select_pin_i,
  input wire logic osc_is_rc_i,
  input wire logic boot_mode_o,
  input wire logic mode_valid_o,
  input wire logic start_in_boot_o,
  input wire logic vectors_from_otp_o,
  input wire logic program_power_o,
  input wire logic otp_programming_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic tk;
  logic tk_rd;
  assign tk = hsel_i && hready_i && htrans_i[1];
  assign tk_rd = tk && !hwrite_i;
  //////////////////////////////////////////////////////////////
  a_bus_okay: assert property (!hresp_o) else $error("bad hresp");
  a_read_wait: assert property (tk_rd |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
  a_mode_latch: assert property ($rose(mode_valid_o) |->
    boot_mode_o == $past(boot_entry_voltage_i && boot_select_pin_i && !osc_is_rc_i))
    else $error("mode latched wrongly");
  a_mode_hold: assert property ($past(mode_valid_o) |-> $stable(boot_mode_o))
    else $error("mode moved");
  a_boot_start: assert property (start_in_boot_o == (mode_valid_o && boot_mode_o))
    else $error("boot start wrong");
  a_otp_vectors: assert property (vectors_from_otp_o == (mode_valid_o && !boot_mode_o))
    else $error("vector source wrong");
  a_power_latch: assert property (program_power_o |-> otp_programming_o)
    else $error("power without latch");
  a_ctrl_read: assert property (tk_rd && haddr_i == 32'h34 |=> ##1
    hrdata_o[31:2] == 30'h0 && (hrdata_o[1] || !hrdata_o[0])) else $error("ctrl read");
  a_ctrl_clear: assert property (tk && hwrite_i && haddr_i == 32'h34 |=>
    !hwdata_i[1] |-> ##1 !program_power_o && !otp_programming_o) else $error("ctrl clear");
  a_mem_blind: assert property (tk_rd && haddr_i[31:14] == 18'h1 |=>
    otp_programming_o |-> ##1 hrdata_o == 32'h0) else $error("read while latched");
endmodule

// ### testbench/epc_cpu_model.sv
// Bus-master model of the CPU core on the register bus
`timescale 1ns/1ps
module epc_cpu_model (
  input wire logic clk_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [31:0] hwdata_o
);
  initial begin
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hwdata_o = 32'h0;
  end
  // Sample where settled, so the edge itself never races the slave
  task automatic wait_rdy(output logic [31:0] q);
    logic r;
    r = 1'b0;
    q = 32'h0;
    while (r !== 1'b1) begin
      @(negedge clk_i);
      r = hready_i;
      q = hrdata_i;
      @(posedge clk_i);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q);
    htrans_o <= 2'h2;
    haddr_o <= a;
    hwrite_o <= w;
    wait_rdy(q);
    htrans_o <= 2'h0;
    haddr_o <= ~a;
    hwdata_o <= w ? d : ~d;
    wait_rdy(q);
    hwdata_o <= ~d;
  endtask
endmodule

// ### testbench/tb_eprom_program_control.sv
// Self-checking bench for the OTP programming control block
`timescale 1ns/1ps
module tb_eprom_program_control;
  localparam int NPROG = 20;
  logic clk_i;
  logic resetn_i;
  logic vpp, bsel, rc, hwrite, hrdy, hresp, boot, mval, sboot, votp, pwr, prg;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  int error_cnt, total_checks, cyc;
  epc_cpu_model i_cpu (.clk_i(clk_i), .hready_i(hrdy), .hrdata_i(hrdata), .haddr_o(haddr),
    .htrans_o(htrans), .hwrite_o(hwrite), .hwdata_o(hwdata));
  epc_top #(.PROG_CYCLES_P(NPROG)) i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(1'b1),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata),
    .boot_entry_voltage_i(vpp), .boot_select_pin_i(bsel), .osc_is_rc_i(rc),
    .boot_mode_o(boot), .mode_valid_o(mval), .start_in_boot_o(sboot),
    .vectors_from_otp_o(votp), .program_power_o(pwr), .otp_programming_o(prg));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Whole run is under two hundred cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_cpu.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    i_cpu.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  function automatic logic [31:0] mode();
    return {28'h0, mval, boot, sboot, votp};
  endfunction
  // Mode pins stay put through the first edge after release
  task automatic do_reset(input logic v, input logic s, input logic r);
    resetn_i <= 1'b0;
    vpp <= v;
    bsel <= s;
    rc <= r;
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  //////////////////////////////////////////////////////////////
  task automatic t_modes();
    do_reset(1'b0, 1'b0, 1'b0);
    chk(mode(), 32'h9);
    do_reset(1'b1, 1'b1, 1'b1);
    chk(mode(), 32'h9);
    do_reset(1'b1, 1'b1, 1'b0);
    chk(mode(), 32'hE);
    bsel <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    chk(mode(), 32'hE);
    rdc(32'h38, 32'h3);
    $display("t_modes done");
  endtask
  task automatic t_ctrl_reg();
    rdc(32'h34, 32'h0);
    wr(32'h34, 32'hFF);
    rdc(32'h34, 32'h3);
    wr(32'h34, 32'h1);
    rdc(32'h34, 32'h0);
    wr(32'h100, 32'hFF);
    rdc(32'h100, 32'h0);
    $display("t_ctrl_reg done");
  endtask
  task automatic t_program();
    logic [31:0] q;
    rdc(32'h7BFC, 32'h0);
    wr(32'h4000, 32'h5A);
    rdc(32'h4000, 32'h0);
    wr(32'h34, 32'h2);
    wr(32'h7BFC, 32'hA5);
    rdc(32'h7BFC, 32'h0);
    rdc(32'h38, 32'h7);
    wr(32'h34, 32'h3);
    #1;
    chk({31'h0, pwr}, 32'h1);
    repeat (NPROG + 4) @(posedge clk_i);
    i_cpu.xfer(1'b0, 32'h38, 32'h0, q);
    chk({31'h0, q[4]}, 32'h1);
    wr(32'h34, 32'h0);
    #1;
    chk({30'h0, pwr, prg}, 32'h0);
    rdc(32'h7BFC, 32'hA5);
    $display("t_program done");
  endtask
  initial begin
    resetn_i = 1'b0;
    vpp = 1'b0;
    bsel = 1'b0;
    rc = 1'b0;
    t_modes();
    t_ctrl_reg();
    t_program();
    wrap_up();
  end
endmodule

bind epc_top epc_checker i_chk (.clk_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
  .hwdata_i, .hready_i, .hreadyout_o, .hresp_o, .hrdata_o, .boot_entry_voltage_i,
  .boot_select_pin_i, .osc_is_rc_i, .boot_mode_o, .mode_valid_o, .start_in_boot_o,
  .vectors_from_otp_o, .program_power_o, .otp_programming_o);
